// file: src/sdi_pkg.sv
// sdi_pkg: constants, command and power-state types, carrier structs
// for the synchronous dram device model and its write buffer.
// assumes every user compiles this file first and names items as sdi_pkg::name.
package sdi_pkg;

   // pin widths
   localparam int ROW_W   = 13;
   localparam int COL_W   = 9;
   localparam int BANK_W  = 2;
   localparam int BANKS   = 4;
   localparam int DATA_W  = 16;
   localparam int LANES   = 2;

   // stored geometry: only the low row and column bits index real storage
   localparam int ROW_KEEP = 2;
   localparam int COL_KEEP = 3;
   localparam int IDX_W    = BANK_W + ROW_KEEP + COL_KEEP;

   // write buffer depth
   localparam int FIFO_DEPTH = 16;

   // address bit that widens a precharge to all banks
   localparam int ALL_BANK_BIT = 10;

   // mode word fields
   localparam int MODE_BL_LSB   = 0;
   localparam int MODE_BL_W     = 3;
   localparam int MODE_TYPE_BIT = 3;
   localparam int MODE_CL_LSB   = 4;
   localparam int MODE_CL_W     = 3;
   localparam logic [MODE_CL_W-1:0] CL_TWO   = 3'h2;
   localparam logic [MODE_BL_W-1:0] BL_FULL  = 3'h7;
   localparam logic [ROW_W-1:0]     MODE_RESET = 13'h0000;

   // burst length counter width, enough for a full page of columns
   localparam int BEAT_W = COL_W + 1;

   // decoded command
   typedef enum logic [3:0] {
      CMD_DESELECT,
      CMD_NOP,
      CMD_MODE_SET,
      CMD_REFRESH,
      CMD_PRECHARGE,
      CMD_ACTIVATE,
      CMD_WRITE,
      CMD_READ,
      CMD_BURST_STOP
   } sdi_cmd_t;

   // internal clocking state
   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_DOWN,
      PWR_SUSPEND,
      PWR_SELF
   } sdi_pwr_t;

   // command pins sampled at one rising edge
   typedef struct packed {
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0]  addr;
      logic [LANES-1:0]  mask;
   } sdi_pins_t;

   // one write beat waiting for the array
   typedef struct packed {
      logic [IDX_W-1:0]  idx;
      logic [DATA_W-1:0] data;
      logic [LANES-1:0]  mask;
   } sdi_wr_t;

endpackage

// file: src/sdi_fifo.sv
// sdi_fifo: flip-flop fifo with valid/ready on both sides.
// assumes one clock and an asynchronous active-low reset; depth is a power of two.
`timescale 1ns/1ps
`default_nettype none
module sdi_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0]   count;
   wire              push;
   wire              pop;

   // honest flags straight from the occupancy count
   assign in_ready  = (count != (PTR_W+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = store[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointers and occupancy
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      end
   end

   // storage needs no reset, it is read only behind count
   always_ff @(posedge clk)
   begin
      if (push)
         store[wr_ptr] <= in_data;
   end

endmodule
`default_nettype wire

// file: src/sdi_sdram_dev.sv
// sdi_sdram_dev: command side of a four-bank, 16-bit synchronous dram, seen from inside the part.
// assumes the controller runs on SYS_CLK and drives all pins from that clock, so no synchronisers;
// the bidirectional data pin is split into in, out and active-low enables per byte lane.
`timescale 1ns/1ps
`default_nettype none
module sdi_sdram_dev #(
   parameter int WR_DEPTH = sdi_pkg::FIFO_DEPTH
) (
   input  wire logic                           SYS_CLK,
   input  wire logic                           RESET_N,
   input  wire logic                           CKE,
   input  wire logic                           CS_N,
   input  wire logic                           RAS_N,
   input  wire logic                           CAS_N,
   input  wire logic                           WE_N,
   input  wire logic [sdi_pkg::ROW_W-1:0]      ADDR,
   input  wire logic                           BANK_SELECT_LO,
   input  wire logic                           BANK_SELECT_HI,
   input  wire logic                           BYTE_MASK_LOW,
   input  wire logic                           BYTE_MASK_HIGH,
   input  wire logic [sdi_pkg::DATA_W-1:0]     DATA_IO_IN,
   output logic      [sdi_pkg::DATA_W-1:0]     DATA_IO_OUT,
   output logic      [sdi_pkg::LANES-1:0]      DATA_IO_OE_N,
   output logic      [sdi_pkg::BANKS-1:0]      BANK_OPEN,
   output logic      [sdi_pkg::ROW_W-1:0]      MODE_WORD,
   output logic                                MODE_VALID,
   output sdi_pkg::sdi_pwr_t                   POWER_STATE,
   output logic                                WRITE_DROPPED
);
   // command decode shared by the take logic
   function automatic sdi_pkg::sdi_cmd_t decode_cmd(input sdi_pkg::sdi_pins_t p);
      sdi_pkg::sdi_cmd_t c;
      c = sdi_pkg::CMD_DESELECT;
      if (!p.cs_n)
      begin
         unique case ({p.ras_n, p.cas_n, p.we_n})
            3'h0: c = sdi_pkg::CMD_MODE_SET;
            3'h1: c = sdi_pkg::CMD_REFRESH;
            3'h2: c = sdi_pkg::CMD_PRECHARGE;
            3'h3: c = sdi_pkg::CMD_ACTIVATE;
            3'h4: c = sdi_pkg::CMD_WRITE;
            3'h5: c = sdi_pkg::CMD_READ;
            3'h6: c = sdi_pkg::CMD_BURST_STOP;
            3'h7: c = sdi_pkg::CMD_NOP;
         endcase
      end
      return c;
   endfunction

   // column of one beat: wraps inside the burst, interleave flips bits
   function automatic logic [sdi_pkg::COL_W-1:0] beat_col(input logic [sdi_pkg::COL_W-1:0] start,
                                                          input logic [sdi_pkg::COL_W-1:0] beat,
                                                          input logic [sdi_pkg::COL_W-1:0] wrap,
                                                          input logic                      ilv);
      logic [sdi_pkg::COL_W-1:0] sum;
      sum = start + beat;
      if (ilv)
         return start ^ (beat & wrap);
      return (start & ~wrap) | (sum & wrap);
   endfunction

   sdi_pkg::sdi_pins_t               pins;
   sdi_pkg::sdi_cmd_t                cmd;
   sdi_pkg::sdi_pwr_t                next_pwr;
   logic                             cke_q;
   logic [sdi_pkg::ROW_KEEP-1:0]     open_row [sdi_pkg::BANKS];
   logic                             burst_on;
   logic                             burst_wr;
   logic [sdi_pkg::BANK_W-1:0]       burst_bank;
   logic [sdi_pkg::COL_W-1:0]        burst_start;
   logic [sdi_pkg::BEAT_W-1:0]       beat;
   logic [sdi_pkg::DATA_W-1:0]       mem [1 << sdi_pkg::IDX_W];
   logic [sdi_pkg::DATA_W-1:0]       rd_data [3];
   logic [2:0]                       rd_valid;
   logic [sdi_pkg::LANES-1:0]        mask_d1;
   logic [sdi_pkg::LANES-1:0]        mask_d2;

   // pins gathered into one sampled bundle
   assign pins = '{cs_n: CS_N, ras_n: RAS_N, cas_n: CAS_N, we_n: WE_N,
                   bank: {BANK_SELECT_HI, BANK_SELECT_LO}, addr: ADDR,
                   mask: {BYTE_MASK_HIGH, BYTE_MASK_LOW}};
   assign cmd  = decode_cmd(pins);

   // internal clock runs only after an edge that saw clock enable high
   wire live     = cke_q;
   wire sel_open = BANK_OPEN[pins.bank];
   wire take_act = live && cmd == sdi_pkg::CMD_ACTIVATE && !sel_open;
   wire take_pre = live && cmd == sdi_pkg::CMD_PRECHARGE;
   wire pre_all  = pins.addr[sdi_pkg::ALL_BANK_BIT];
   wire take_mrs = live && cmd == sdi_pkg::CMD_MODE_SET && BANK_OPEN == '0;
   // access to an idle bank is refused, the part has no row to use
   wire start_rd = live && cmd == sdi_pkg::CMD_READ && sel_open;
   wire start_wr = live && cmd == sdi_pkg::CMD_WRITE && sel_open;
   wire start    = start_rd || start_wr;
   wire kill     = (cmd == sdi_pkg::CMD_BURST_STOP) ||
                   (take_pre && (pre_all || pins.bank == burst_bank));
   wire cont     = live && burst_on && !start && !kill;

   // burst length and latency from the mode word
   wire [sdi_pkg::MODE_BL_W-1:0] bl_code  = MODE_WORD[sdi_pkg::MODE_BL_LSB +: sdi_pkg::MODE_BL_W];
   wire [sdi_pkg::MODE_CL_W-1:0] cl_code  = MODE_WORD[sdi_pkg::MODE_CL_LSB +: sdi_pkg::MODE_CL_W];
   wire                          ilv      = MODE_WORD[sdi_pkg::MODE_TYPE_BIT];
   wire                          bl_full  = (bl_code == sdi_pkg::BL_FULL);
   wire [sdi_pkg::BEAT_W-1:0]    bl_len   = bl_full ? sdi_pkg::BEAT_W'(1 << sdi_pkg::COL_W) :
                                            (bl_code[2] ? sdi_pkg::BEAT_W'(1) :
                                             sdi_pkg::BEAT_W'(1) << bl_code[1:0]);
   wire [sdi_pkg::COL_W-1:0]     wrap     = sdi_pkg::COL_W'(bl_len - sdi_pkg::BEAT_W'(1));
   wire                          ilv_eff  = ilv && !bl_full;

   // current beat: the command itself or the running burst
   wire [sdi_pkg::BANK_W-1:0]    cur_bank  = start ? pins.bank : burst_bank;
   wire [sdi_pkg::COL_W-1:0]     cur_start = start ? pins.addr[sdi_pkg::COL_W-1:0] : burst_start;
   wire [sdi_pkg::COL_W-1:0]     cur_beat  = start ? '0 : beat[sdi_pkg::COL_W-1:0];
   wire [sdi_pkg::COL_W-1:0]     cur_col   = beat_col(cur_start, cur_beat, wrap, ilv_eff);
   wire [sdi_pkg::IDX_W-1:0]     cur_idx   = {cur_bank, open_row[cur_bank],
                                              cur_col[sdi_pkg::COL_KEEP-1:0]};
   wire                          rd_beat   = start_rd || (cont && !burst_wr);
   wire                          wr_beat   = start_wr || (cont && burst_wr);
   wire [sdi_pkg::BEAT_W-1:0]    beat_nx   = (start ? '0 : beat) + sdi_pkg::BEAT_W'(1);

   // write buffer: beats carry their mask, the array port drains it
   sdi_pkg::sdi_wr_t wr_in;
   sdi_pkg::sdi_wr_t wr_out;
   logic             wr_ready;
   logic             wr_pend;
   assign wr_in = '{idx: cur_idx, data: DATA_IO_IN, mask: pins.mask};
   // reads own the single array port, so a read burst stalls the drain
   wire drain = wr_pend && !rd_beat;

   sdi_fifo #(
      .WIDTH ($bits(sdi_pkg::sdi_wr_t)),
      .DEPTH (WR_DEPTH)
   ) u_wr_fifo (
      .clk       (SYS_CLK),
      .reset_n   (RESET_N),
      .in_valid  (wr_beat),
      .in_ready  (wr_ready),
      .in_data   (wr_in),
      .out_valid (wr_pend),
      .out_ready (!rd_beat),
      .out_data  (wr_out)
   );

   // clock enable history and power state
   always_comb
   begin
      next_pwr = POWER_STATE;
      if (CKE)
         next_pwr = sdi_pkg::PWR_RUN;
      else if (live && cmd == sdi_pkg::CMD_REFRESH && BANK_OPEN == '0)
         next_pwr = sdi_pkg::PWR_SELF;
      else if (live)
         next_pwr = (burst_on || start || rd_valid != '0) ? sdi_pkg::PWR_SUSPEND : sdi_pkg::PWR_DOWN;
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         cke_q       <= 1'b0;
         POWER_STATE <= sdi_pkg::PWR_DOWN;
      end
      else
      begin
         cke_q       <= CKE;
         POWER_STATE <= next_pwr;
      end
   end

   // bank open flags and the mode word
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         BANK_OPEN  <= '0;
         MODE_WORD  <= sdi_pkg::MODE_RESET;
         MODE_VALID <= 1'b0;
      end
      else
      begin
         for (int b = 0; b < sdi_pkg::BANKS; b++)
         begin
            if (take_pre && (pre_all || pins.bank == sdi_pkg::BANK_W'(b)))
               BANK_OPEN[b] <= 1'b0;
            else if (take_act && pins.bank == sdi_pkg::BANK_W'(b))
               BANK_OPEN[b] <= 1'b1;
         end
         if (take_mrs)
         begin
            MODE_WORD  <= pins.addr;
            MODE_VALID <= 1'b1;
         end
      end
   end

   // open row per bank, latched from the low ROW_KEEP bits of the row address
   always_ff @(posedge SYS_CLK)
   begin
      if (take_act)
         open_row[pins.bank] <= pins.addr[sdi_pkg::ROW_KEEP-1:0];
   end

   // burst sequencer; a new access restarts it with the full length
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         burst_on    <= 1'b0;
         burst_wr    <= 1'b0;
         burst_bank  <= '0;
         burst_start <= '0;
         beat        <= '0;
      end
      else if (start || cont)
      begin
         burst_on    <= (beat_nx != bl_len);
         burst_wr    <= start ? start_wr : burst_wr;
         burst_bank  <= cur_bank;
         burst_start <= cur_start;
         beat        <= beat_nx;
      end
      else if (live && kill)
         burst_on <= 1'b0;
   end

   // array write, masked lanes untouched
   always_ff @(posedge SYS_CLK)
   begin
      for (int l = 0; l < sdi_pkg::LANES; l++)
      begin
         if (drain && !wr_out.mask[l])
            mem[wr_out.idx][l*8 +: 8] <= wr_out.data[l*8 +: 8];
      end
   end

   // read pipeline, frozen while internal clocking is stopped
   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rd_valid <= '0;
         mask_d1  <= '1;
         mask_d2  <= '1;
         rd_data  <= '{default: '0};
      end
      else if (live)
      begin
         rd_valid <= {rd_valid[1:0], rd_beat};
         rd_data  <= '{mem[cur_idx], rd_data[0], rd_data[1]};
         mask_d1  <= pins.mask;
         mask_d2  <= mask_d1;
      end
   end

   // output stage: latency 2 or 3, mask sampled two edges earlier floats the lane
   wire                          cl2   = (cl_code == sdi_pkg::CL_TWO);
   wire                          tap_v = cl2 ? rd_valid[1] : rd_valid[2];
   wire [sdi_pkg::DATA_W-1:0]    tap_d = cl2 ? rd_data[1] : rd_data[2];

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         DATA_IO_OUT   <= '0;
         DATA_IO_OE_N  <= '1;
         WRITE_DROPPED <= 1'b0;
      end
      else
      begin
         WRITE_DROPPED <= wr_beat && !wr_ready;   // buffer full, beat lost
         if (live)
         begin
            DATA_IO_OUT  <= tap_d;
            DATA_IO_OE_N <= ~({sdi_pkg::LANES{tap_v}} & ~mask_d2);
         end
      end
   end

endmodule
`default_nettype wire

// file: dv/sdi_sva.sv
// sdi_sva: port checks for the dram device model.
// assumes one clock SYS_CLK and an async active-low RESET_N.
`timescale 1ns/1ps
`default_nettype none
module sdi_sva (
   input wire logic                          SYS_CLK,
   input wire logic                          RESET_N,
   input wire logic                          CKE,
   input wire logic                          CS_N,
   input wire logic                          RAS_N,
   input wire logic                          CAS_N,
   input wire logic                          WE_N,
   input wire logic [sdi_pkg::ROW_W-1:0]     ADDR,
   input wire logic                          BANK_SELECT_LO,
   input wire logic                          BANK_SELECT_HI,
   input wire logic                          BYTE_MASK_LOW,
   input wire logic                          BYTE_MASK_HIGH,
   input wire logic [sdi_pkg::LANES-1:0]     DATA_IO_OE_N,
   input wire logic [sdi_pkg::BANKS-1:0]     BANK_OPEN,
   input wire logic [sdi_pkg::ROW_W-1:0]     MODE_WORD,
   input wire logic                          MODE_VALID,
   input wire sdi_pkg::sdi_pwr_t             POWER_STATE
);
   logic cke_q;
   // the part sees clock enable one edge late
   always_ff @(posedge SYS_CLK or negedge RESET_N)
      if (!RESET_N)
         cke_q <= 1'b0;
      else
         cke_q <= CKE;
   // command decode as the part takes it
   wire logic [1:0] bank = {BANK_SELECT_HI, BANK_SELECT_LO};
   wire logic       go   = cke_q && !CS_N;
   wire logic       act  = go && !RAS_N && CAS_N && WE_N;
   wire logic       pre  = go && !RAS_N && CAS_N && !WE_N;
   wire logic       mrs  = go && !RAS_N && !CAS_N && !WE_N;
   wire logic       rd   = go && RAS_N && !CAS_N && WE_N;
   default clocking @(posedge SYS_CLK);
   endclocking
   default disable iff (!RESET_N);
   a_deselect_ignored: assert property (CS_N |=> $stable(BANK_OPEN) && $stable(MODE_WORD))
      else $error("state moved while deselected");
   a_activate_opens: assert property (act |=> BANK_OPEN[$past(bank)])
      else $error("activate did not open the bank");
   a_precharge_all: assert property (pre && ADDR[10] |=> BANK_OPEN == 4'h0)
      else $error("all-bank precharge left a bank open");
   a_precharge_one: assert property (pre && !ADDR[10] |=> !BANK_OPEN[$past(bank)])
      else $error("bank precharge left the bank open");
   a_mode_load: assert property (mrs && BANK_OPEN == 4'h0 |=> MODE_VALID && MODE_WORD == $past(ADDR))
      else $error("mode set not loaded");
   a_mode_refused: assert property (mrs && BANK_OPEN != 4'h0 |=> $stable(MODE_WORD))
      else $error("mode set taken with a bank open");
   a_read_lane_on: assert property (rd && !BYTE_MASK_LOW && !BYTE_MASK_HIGH && MODE_WORD[6:4] == 3'h2
      && BANK_OPEN[bank] ##1 cke_q [*2] |=> DATA_IO_OE_N == 2'h0)
      else $error("read lanes not driven two cycles on");
   // mask pipeline only advances on live edges, so all three must have been live
   a_mask_floats: assert property (!DATA_IO_OE_N[1] && $past(cke_q) && $past(cke_q, 2)
      && $past(cke_q, 3) |-> !$past(BYTE_MASK_HIGH, 3))
      else $error("masked high lane driven");
   a_power_run: assert property (CKE |=> POWER_STATE == sdi_pkg::PWR_RUN)
      else $error("clock enable high but not running");
   a_power_stop: assert property (!CKE |=> POWER_STATE != sdi_pkg::PWR_RUN)
      else $error("clock enable low but still running");
endmodule
`default_nettype wire

// file: dv/sdi_ctrl_model.sv
// sdi_ctrl_model: controller side driving the dram command pins.
// assumes the bench resolves the data wire and calls the tasks in turn.
`timescale 1ns/1ps
`default_nettype none
module sdi_ctrl_model #(
   parameter int PAUSE = 10000,
   parameter int T_RCD = 2,
   parameter int T_RC  = 4,
   parameter int T_RSC = 2
) (
   input  wire logic              SYS_CLK,
   output var sdi_pkg::sdi_pins_t pins,
   output var logic               cke,
   output var logic [15:0]        wdata
);
   // power-up pins: no operation, masks and clock enable high
   initial
   begin
      pins = {4'h7, 2'h0, 13'h0000, 2'h3};
      cke = 1'b1;
      wdata = 16'h0000;
   end
   // one command on the next edge; c is cs, ras, cas, we
   task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                      input logic [1:0] m, input logic [15:0] d);
      @(posedge SYS_CLK);
      pins <= {c, b, a, m};
      wdata <= d;
   endtask
   // released data wire moves, so a stale value never looks valid
   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge SYS_CLK);
         {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h7;
         wdata <= ~wdata;
      end
   endtask
   task automatic set_cke(input logic v);
      @(posedge SYS_CLK);
      cke <= v;
   endtask
   // strobes and clock enable change together, so both meet the same edge
   task automatic cmd_cke(input logic [3:0] c, input logic v);
      @(posedge SYS_CLK);
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= c;
      cke <= v;
   endtask
   // open a row, then hold off any access
   task automatic act(input logic [1:0] b, input logic [12:0] r);
      cmd(4'h3, b, r, 2'h0, wdata);
      idle(T_RCD);
   endtask
   // close, then rest a full row cycle before reopening
   task automatic pre(input logic [1:0] b, input logic [12:0] a);
      cmd(4'h2, b, a, 2'h0, wdata);
      idle(T_RC);
   endtask
   task automatic init(input logic [12:0] mode);
      idle(PAUSE);
      pre(2'h0, 13'h0400);
      repeat (8)
      begin
         cmd(4'h1, 2'h0, 13'h0000, 2'h0, wdata);
         idle(T_RC);
      end
      cmd(4'h0, 2'h0, mode, 2'h0, wdata);
      idle(T_RSC);
   endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// tb: scenario bench for the dram device model and its fifo.
// assumes the controller model drives all command pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic               SYS_CLK = 1'b0;
   logic               RESET_N = 1'b0;
   sdi_pkg::sdi_pins_t pins;
   logic               cke;
   logic [15:0]        wdata;
   logic [15:0]        dout;
   logic [1:0]         oe_n;
   logic [3:0]         bank_open;
   logic [12:0]        mode_word;
   logic               mode_valid;
   logic               dropped;
   sdi_pkg::sdi_pwr_t  pwr;
   int                 mismatches = 0;
   int                 num_checks = 0;
   int                 cycles = 0;
   // data wire: each lane is the device's while it drives, else the controller's
   wire logic [15:0] dq = {oe_n[1] ? wdata[15:8] : dout[15:8], oe_n[0] ? wdata[7:0] : dout[7:0]};
   always #10 SYS_CLK = ~SYS_CLK;
   sdi_ctrl_model #(.PAUSE(10000)) sdi_ctrl_model_i (.SYS_CLK(SYS_CLK), .pins(pins), .cke(cke), .wdata(wdata));
   sdi_sdram_dev #(.WR_DEPTH(16)) sdi_sdram_dev_i (
      .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CKE(cke), .CS_N(pins.cs_n), .RAS_N(pins.ras_n),
      .CAS_N(pins.cas_n), .WE_N(pins.we_n), .ADDR(pins.addr), .BANK_SELECT_LO(pins.bank[0]),
      .BANK_SELECT_HI(pins.bank[1]), .BYTE_MASK_LOW(pins.mask[0]), .BYTE_MASK_HIGH(pins.mask[1]),
      .DATA_IO_IN(dq), .DATA_IO_OUT(dout), .DATA_IO_OE_N(oe_n), .BANK_OPEN(bank_open),
      .MODE_WORD(mode_word), .MODE_VALID(mode_valid), .POWER_STATE(pwr), .WRITE_DROPPED(dropped));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // let the sampling edge pass, then look between edges
   task automatic settle(input int n);
      sdi_ctrl_model_i.idle(n);
      @(negedge SYS_CLK);
   endtask
   task automatic s_init;
      @(negedge SYS_CLK);
      check("oe_n", 16'(oe_n), 16'h0003);
      check("mode_valid", 16'(mode_valid), 16'h0000);
      sdi_ctrl_model_i.init(13'h0020);
      @(negedge SYS_CLK);
      check("mode_word", 16'(mode_word), 16'h0020);
      check("mode_valid", 16'(mode_valid), 16'h0001);
      $display("test init done");
   endtask
   task automatic s_banks;
      sdi_ctrl_model_i.act(2'h1, 13'h1fff);
      @(negedge SYS_CLK);
      check("open", 16'(bank_open), 16'h0002);
      sdi_ctrl_model_i.act(2'h2, 13'h0001);
      sdi_ctrl_model_i.cmd(4'h0, 2'h0, 13'h0030, 2'h0, wdata);
      settle(1);
      check("open", 16'(bank_open), 16'h0006);
      check("mode kept", 16'(mode_word), 16'h0020);
      sdi_ctrl_model_i.pre(2'h1, 13'h1bff);
      @(negedge SYS_CLK);
      check("open", 16'(bank_open), 16'h0004);
      sdi_ctrl_model_i.act(2'h1, 13'h0000);
      sdi_ctrl_model_i.pre(2'h0, 13'h0400);
      @(negedge SYS_CLK);
      check("open", 16'(bank_open), 16'h0000);
      $display("test banks done");
   endtask
   task automatic s_deselect;
      sdi_ctrl_model_i.cmd(4'hb, 2'h1, 13'h0000, 2'h0, wdata);
      settle(1);
      check("deselect", 16'(bank_open), 16'h0000);
      sdi_ctrl_model_i.set_cke(1'b0);
      sdi_ctrl_model_i.cmd(4'h3, 2'h1, 13'h0000, 2'h0, wdata);
      settle(2);
      check("frozen", 16'(bank_open), 16'h0000);
      check("power", 16'(pwr), 16'(sdi_pkg::PWR_DOWN));
      sdi_ctrl_model_i.set_cke(1'b1);
      settle(2);
      check("power", 16'(pwr), 16'(sdi_pkg::PWR_RUN));
      // refresh with clock enable dropping and all banks idle enters self refresh
      sdi_ctrl_model_i.cmd_cke(4'h1, 1'b0);
      settle(1);
      check("power", 16'(pwr), 16'(sdi_pkg::PWR_SELF));
      sdi_ctrl_model_i.set_cke(1'b1);
      settle(1);
      check("power", 16'(pwr), 16'(sdi_pkg::PWR_RUN));
      $display("test deselect done");
   endtask
   task automatic s_write_read;
      sdi_ctrl_model_i.act(2'h0, 13'h0003);
      sdi_ctrl_model_i.cmd(4'h4, 2'h0, 13'h0002, 2'h0, 16'h1234);
      sdi_ctrl_model_i.cmd(4'h4, 2'h0, 13'h0002, 2'h2, 16'hab56);
      settle(4);
      check("dropped", 16'(dropped), 16'h0000);
      sdi_ctrl_model_i.cmd(4'h5, 2'h0, 13'h0002, 2'h0, wdata);
      settle(3);
      check("read", dout, 16'h1256);
      check("oe", 16'(oe_n), 16'h0000);
      sdi_ctrl_model_i.cmd(4'h5, 2'h0, 13'h0002, 2'h1, wdata);
      settle(3);
      check("oe", 16'(oe_n), 16'h0001);
      check("high", 16'(dout[15:8]), 16'h0012);
      settle(1);
      check("oe", 16'(oe_n), 16'h0003);
      sdi_ctrl_model_i.pre(2'h0, 13'h0400);
      $display("test write read done");
   endtask
   // back-to-back writes pass the write buffer in order, then read back one by one
   task automatic s_buffer;
      sdi_ctrl_model_i.act(2'h1, 13'h0002);
      @(negedge SYS_CLK);
      check("open", 16'(bank_open), 16'h0002);
      for (int c = 4; c < 8; c++)
         sdi_ctrl_model_i.cmd(4'h4, 2'h1, 13'(c), 2'h0, 16'(16'h0a00 + c));
      settle(2);
      check("dropped", 16'(dropped), 16'h0000);
      for (int c = 4; c < 8; c++)
      begin
         sdi_ctrl_model_i.cmd(4'h5, 2'h1, 13'(c), 2'h0, wdata);
         settle(3);
         check("buffer", dout, 16'(16'h0a00 + c));
      end
      sdi_ctrl_model_i.pre(2'h1, 13'h0400);
      $display("test buffer done");
   endtask
   // a hang ends the run here
   always @(posedge SYS_CLK)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         conclude;
      end
   end
   initial
   begin
      repeat (2) @(posedge SYS_CLK);
      RESET_N <= 1'b1;
      s_init;
      s_banks;
      s_deselect;
      s_write_read;
      s_buffer;
      conclude;
   end
endmodule
bind sdi_sdram_dev sdi_sva sdi_sva_i (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CKE(CKE), .CS_N(CS_N),
   .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .ADDR(ADDR), .BANK_SELECT_LO(BANK_SELECT_LO),
   .BANK_SELECT_HI(BANK_SELECT_HI), .BYTE_MASK_LOW(BYTE_MASK_LOW), .BYTE_MASK_HIGH(BYTE_MASK_HIGH),
   .DATA_IO_OE_N(DATA_IO_OE_N), .BANK_OPEN(BANK_OPEN), .MODE_WORD(MODE_WORD), .MODE_VALID(MODE_VALID),
   .POWER_STATE(POWER_STATE));
`default_nettype wire
